// >>> hw/adrc_map.vh
// adrc_map.vh: register indices, field positions, reset values, timing
// assumes: included by the converter control files of this block only
`ifndef ADRC_MAP_VH
`define ADRC_MAP_VH

// ------------------------------------------------------------
// register indices on the 8-bit bus (byte addresses)
// ------------------------------------------------------------
`define ADRC_A_HI        4'h0
`define ADRC_A_LO        4'h1
`define ADRC_B_HI        4'h2
`define ADRC_B_LO        4'h3
`define ADRC_C_HI        4'h4
`define ADRC_C_LO        4'h5
`define ADRC_D_HI        4'h6
`define ADRC_D_LO        4'h7
`define ADRC_CSR         4'h8
`define ADRC_CR          4'h9

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ADRC_CSR_END     7
`define ADRC_CSR_START   5
`define ADRC_CSR_SCAN    4
`define ADRC_CSR_CHSEL   3
`define ADRC_CR_TRG_HI   5
`define ADRC_CR_TRG_LO   4
`define ADRC_CR_CKS_HI   3
`define ADRC_CR_CKS_LO   2
`define ADRC_RES_LSB     6

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ADRC_RES_RST     16'h0000
`define ADRC_CSR_RST     8'h00
`define ADRC_CR_RST      8'h00

// ------------------------------------------------------------
// conversion times in states per channel
// ------------------------------------------------------------
`define ADRC_T_512       10'h200
`define ADRC_T_256       10'h100
`define ADRC_T_128       10'h080
`define ADRC_T_64        10'h040

`endif

// >>> hw/adrc_result_mem.v
// adrc_result_mem.v: four 16-bit result registers with registered read
// assumes: one writer from the sequencer, one reader from the bus
`timescale 1ns/1ps
`include "adrc_map.vh"

module adrc_result_mem
(
	input  wire        core_clk_i,
	input  wire        rst_n_i,
	input  wire        wr_en_i,
	input  wire [1:0]  wr_idx_i,
	input  wire [9:0]  wr_data_i,
	input  wire [1:0]  rd_idx_i,
	output reg  [15:0] rd_data_o
);

	reg [15:0] res_r [0:3];

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : slot
			always @(posedge core_clk_i)
			begin
				if (!rst_n_i)
					res_r[g] <= `ADRC_RES_RST;
				else if (wr_en_i && wr_idx_i == g)
					res_r[g] <= {wr_data_i, 6'h00};
			end
		end
	endgenerate

	always @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			rd_data_o <= `ADRC_RES_RST;
		else
			rd_data_o <= res_r[rd_idx_i];
	end

endmodule

// >>> hw/adrc_ctrl.v
// adrc_ctrl.v: converter sequencing, end flag and byte-wide readout
// assumes: synchronous 8-bit bus, analog core returns a 10-bit sample
// whenever conv_done_i pulses for the channel on ana_ch_o
`timescale 1ns/1ps
`include "adrc_map.vh"

// Function
// - four read-only 16-bit result registers
// - A=ch0, B=ch1, C=ch2/14, D=ch3/15
// - result left-aligned, low six bits zero
// - result registers reset to zero
// - results reached over 8-bit bus
// - high read latches low byte for later
// - end flag set after single conversion
// - scan sets end flag after all channels
// - end flag cleared by read-one-then-write-zero
// - transfer controller read also clears flag
// - clock select gives 512/256/128/64 states, single or scan
// - trigger pin enabled when both selects one
// - trigger falling edge sets start bit
// - triggered conversion behaves like software start
module adrc_ctrl
(
	input  wire        core_clk_i,
	input  wire        rst_n_i,
	input  wire [3:0]  bus_addr_i,
	input  wire        bus_rd_i,
	input  wire        bus_wr_i,
	input  wire [7:0]  bus_wdata_i,
	output reg  [7:0]  bus_rdata_o,
	input  wire        xfer_ack_i,
	input  wire        xfer_disable_on_end_select_i,
	input  wire        xfer_cnt_nz_i,
	input  wire        ext_trig_i,
	input  wire        ch_hi_sel_i,
	input  wire        conv_done_i,
	input  wire [9:0]  conv_data_i,
	output reg  [3:0]  ana_ch_o,
	output reg         conv_busy_o,
	output reg         end_req_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	localparam ST_IDLE = 1'b0;
	localparam ST_CONV = 1'b1;

	reg        state_r;
	reg        end_flag_r;
	reg        end_seen_r;
	reg        start_r;
	reg        scan_r;
	reg [1:0]  chsel_r;
	reg [1:0]  cur_r;
	reg [7:0]  ctrl_r;
	reg [9:0]  cnt_r;
	reg        trig_d_r;
	reg [7:0]  temp_r;
	reg        wr_en_r;
	reg [1:0]  wr_idx_r;
	reg [9:0]  wr_data_r;
	wire [15:0] mem_rd;
	wire [1:0]  rd_idx;
	wire        is_res_rd;
	wire        hi_rd;
	wire        trig_en;
	wire        trig_fall;
	wire        step_end;
	wire        last_ch;
	wire        set_end;
	wire        clr_sw;
	wire        clr_xfer;
	wire [9:0]  conv_time;
	wire        start_wr;
	wire        scan_go;
	wire [1:0]  chsel_go;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function [9:0] cks_time;
		input [1:0] cks;
		begin
			case (cks)
				2'b00:   cks_time = `ADRC_T_512;
				2'b01:   cks_time = `ADRC_T_256;
				2'b10:   cks_time = `ADRC_T_128;
				default: cks_time = `ADRC_T_64;
			endcase
		end
	endfunction

	// result slot to analog channel; C and D take the upper pair on request
	function [3:0] slot_ch;
		input [1:0] slot;
		input       hi;
		begin
			slot_ch = {hi & slot[1], hi & slot[1], slot};
		end
	endfunction

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	assign is_res_rd = bus_rd_i && (bus_addr_i < `ADRC_CSR);
	assign hi_rd     = is_res_rd && !bus_addr_i[0];
	assign rd_idx    = bus_addr_i[2:1];
	assign trig_en   = ctrl_r[`ADRC_CR_TRG_HI] &
	                   ctrl_r[`ADRC_CR_TRG_LO];
	assign trig_fall = trig_en && trig_d_r && !ext_trig_i;
	assign conv_time = cks_time(ctrl_r[`ADRC_CR_CKS_HI:`ADRC_CR_CKS_LO]);
	assign step_end  = (state_r == ST_CONV) && conv_done_i &&
	                   (cnt_r >= conv_time - 10'h001);
	assign last_ch   = !scan_r || (cur_r == chsel_r);
	assign set_end   = step_end && last_ch;
	assign clr_sw    = bus_wr_i && bus_addr_i == `ADRC_CSR &&
	                   !bus_wdata_i[`ADRC_CSR_END] && end_seen_r;
	assign clr_xfer  = xfer_ack_i && is_res_rd && !xfer_disable_on_end_select_i &&
	                   xfer_cnt_nz_i;

	// ------------------------------------------------------------
	// start decode
	// ------------------------------------------------------------
	// a start write carries its own mode and slot, but the field
	// registers only take them at this same edge; read them off the bus
	// so the first channel is never picked from the previous setting
	assign start_wr  = bus_wr_i && bus_addr_i == `ADRC_CSR &&
	                   bus_wdata_i[`ADRC_CSR_START];
	assign scan_go   = start_wr ? bus_wdata_i[`ADRC_CSR_SCAN] : scan_r;
	assign chsel_go  = start_wr ? bus_wdata_i[1:0] : chsel_r;

	// memory holds the four results; read data registered one cycle
	adrc_result_mem u_mem
	(
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.wr_en_i    (wr_en_r),
		.wr_idx_i   (wr_idx_r),
		.wr_data_i  (wr_data_r),
		.rd_idx_i   (rd_idx),
		.rd_data_o  (mem_rd)
	);

	// ------------------------------------------------------------
	// register bus: read data one cycle after the strobe
	// ------------------------------------------------------------
	reg       rd_d_r;
	reg [3:0] addr_d_r;
	always @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			rd_d_r   <= 1'b0;
			addr_d_r <= 4'h0;
		end
		else
		begin
			rd_d_r   <= bus_rd_i;
			addr_d_r <= bus_addr_i;
		end
	end

	always @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			temp_r <= 8'h00;
		else if (rd_d_r && addr_d_r < `ADRC_CSR && !addr_d_r[0])
			temp_r <= mem_rd[7:0];
	end

	// read mux; hi byte straight from the result, lo byte from temp
	always @*
	begin
		bus_rdata_o = 8'h00;
		if (rd_d_r)
		begin
			if (addr_d_r < `ADRC_CSR && !addr_d_r[0])
				bus_rdata_o = mem_rd[15:8];
			else if (addr_d_r < `ADRC_CSR)
				bus_rdata_o = temp_r;
			else if (addr_d_r == `ADRC_CSR)
				bus_rdata_o = {end_flag_r, 1'b0, start_r, scan_r,
				               2'b00, chsel_r};
			else if (addr_d_r == `ADRC_CR)
				bus_rdata_o = ctrl_r;
		end
	end

	// ------------------------------------------------------------
	// control registers and end flag
	// ------------------------------------------------------------
	always @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			end_flag_r <= 1'b0;
			end_seen_r <= 1'b0;
			scan_r     <= 1'b0;
			chsel_r    <= 2'b00;
			ctrl_r     <= `ADRC_CR_RST;
			trig_d_r   <= 1'b1;
			end_req_o  <= 1'b0;
		end
		else
		begin
			trig_d_r  <= ext_trig_i;
			end_req_o <= set_end;
			// set wins over any clear in the same cycle
			if (set_end)
				end_flag_r <= 1'b1;
			else if (clr_sw || clr_xfer)
				end_flag_r <= 1'b0;
			// arm only on a read that saw the flag as one
			// any clear disarms; a new read of one is needed
			if (set_end || clr_sw || clr_xfer)
				end_seen_r <= 1'b0;
			else if (bus_rd_i && bus_addr_i == `ADRC_CSR && end_flag_r)
				end_seen_r <= 1'b1;
			if (bus_wr_i && bus_addr_i == `ADRC_CSR && state_r == ST_IDLE)
			begin
				scan_r  <= bus_wdata_i[`ADRC_CSR_SCAN];
				chsel_r <= bus_wdata_i[1:0];
			end
			if (bus_wr_i && bus_addr_i == `ADRC_CR)
				ctrl_r <= bus_wdata_i;
		end
	end

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	always @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			state_r     <= ST_IDLE;
			start_r     <= 1'b0;
			cur_r       <= 2'b00;
			cnt_r       <= 10'h000;
			wr_en_r     <= 1'b0;
			wr_idx_r    <= 2'b00;
			wr_data_r   <= 10'h000;
			ana_ch_o    <= 4'h0;
			conv_busy_o <= 1'b0;
		end
		else
		begin
			wr_en_r <= 1'b0;
			case (state_r)
				ST_IDLE:
				begin
					if (trig_fall || start_wr)
					begin
						start_r     <= 1'b1;
						state_r     <= ST_CONV;
						cnt_r       <= 10'h000;
						conv_busy_o <= 1'b1;
						ana_ch_o    <= slot_ch(scan_go ? 2'b00 : chsel_go,
						                       ch_hi_sel_i);
						if (!scan_go)
							cur_r <= chsel_go;
						else
							cur_r <= 2'b00;
					end
				end
				ST_CONV:
				begin
					if (cnt_r != 10'h3ff)
						cnt_r <= cnt_r + 10'h001;
					if (bus_wr_i && bus_addr_i == `ADRC_CSR &&
					    !bus_wdata_i[`ADRC_CSR_START])
					begin
						state_r     <= ST_IDLE;
						start_r     <= 1'b0;
						conv_busy_o <= 1'b0;
					end
					else if (step_end)
					begin
						wr_en_r   <= 1'b1;
						wr_idx_r  <= cur_r;
						wr_data_r <= conv_data_i;
						cnt_r     <= 10'h000;
						if (last_ch)
						begin
							state_r     <= ST_IDLE;
							start_r     <= 1'b0;
							conv_busy_o <= 1'b0;
						end
						else
						begin
							cur_r    <= cur_r + 2'b01;
							ana_ch_o <= slot_ch(cur_r + 2'b01, ch_hi_sel_i);
						end
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

endmodule

// >>> tb/adrc_ana_model.sv
// adrc_ana_model.sv: analog core stand-in that answers conversion steps
// assumes: clocked with the block, sees busy and channel from the block
`timescale 1ns/1ps
module adrc_ana_model
(
	input  wire       clk_i,
	input  wire       busy_i,
	input  wire       slow_i,
	input  wire [3:0] ch_i,
	input  wire [5:0] seed_i,
	output reg        done_o = 1'b0,
	output wire [9:0] data_o
);
	// ----------------
	// sample pacing
	// ----------------
	reg ph_r = 1'b0;
	// slow pacing answers on alternate cycles only
	always @(posedge clk_i)
	begin
		ph_r   <= ~ph_r & slow_i;
		done_o <= busy_i & (~slow_i | ph_r);
	end
	// inverted outside a conversion so no stale sample looks valid
	assign data_o = busy_i ? {ch_i, seed_i} : ~{ch_i, seed_i};
endmodule

// >>> tb/adrc_ctrl_monitor.sv
// adrc_ctrl_monitor.sv: port assertions for the converter control block
// assumes: bound to each adrc_ctrl, one clock, sync active-low reset
`timescale 1ns/1ps
module adrc_ctrl_monitor
(
	input wire       core_clk_i,
	input wire       rst_n_i,
	input wire [3:0] bus_addr_i,
	input wire       bus_rd_i,
	input wire       bus_wr_i,
	input wire [7:0] bus_wdata_i,
	input wire [7:0] bus_rdata_o,
	input wire       xfer_ack_i,
	input wire       xfer_disable_on_end_select_i,
	input wire       xfer_cnt_nz_i,
	input wire       ext_trig_i,
	input wire       ch_hi_sel_i,
	input wire       conv_done_i,
	input wire [9:0] conv_data_i,
	input wire [3:0] ana_ch_o,
	input wire       conv_busy_o,
	input wire       end_req_o
);
	// ----------------
	// assertions
	// ----------------
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	idle_rdata_a: assert property (!bus_rd_i |=> bus_rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	lo_zero_a: assert property ((bus_rd_i && bus_addr_i[0]
		&& bus_addr_i < 4'h8) |=> bus_rdata_o[5:0] == 6'h00)
		else $error("low result bits not zero");
	unmapped_a: assert property ((bus_rd_i && bus_addr_i > 4'h9)
		|=> bus_rdata_o == 8'h00) else $error("unmapped read not zero");
	req_pulse_a: assert property (end_req_o |=> !end_req_o)
		else $error("end request longer than one cycle");
	req_busy_a: assert property (end_req_o |-> ($past(conv_busy_o, 3)
		|| $past(conv_busy_o, 2) || $past(conv_busy_o)))
		else $error("end request without conversion");
	sw_start_a: assert property ((bus_wr_i && bus_addr_i == 4'h8
		&& bus_wdata_i[5] && !conv_busy_o) |=> conv_busy_o)
		else $error("start write did not start");
	ch_low_a: assert property ((conv_busy_o && !ch_hi_sel_i)
		|-> ana_ch_o < 4'h4) else $error("bad low channel");
	ch_high_a: assert property ((conv_busy_o && ch_hi_sel_i)
		|-> (ana_ch_o < 4'h2 || ana_ch_o > 4'hd))
		else $error("bad high channel");
	cover property (end_req_o && ch_hi_sel_i);
	cover property (bus_rd_i && xfer_ack_i && !xfer_disable_on_end_select_i);
	cover property ($fell(ext_trig_i) ##[1:6] conv_busy_o);
endmodule
bind adrc_ctrl adrc_ctrl_monitor u_mon (.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i),
	.bus_wr_i(bus_wr_i), .bus_wdata_i(bus_wdata_i),
	.bus_rdata_o(bus_rdata_o), .xfer_ack_i(xfer_ack_i),
	.xfer_disable_on_end_select_i(xfer_disable_on_end_select_i), .xfer_cnt_nz_i(xfer_cnt_nz_i),
	.ext_trig_i(ext_trig_i), .ch_hi_sel_i(ch_hi_sel_i),
	.conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
	.ana_ch_o(ana_ch_o), .conv_busy_o(conv_busy_o), .end_req_o(end_req_o));

// >>> tb/adrc_ctrl_tb.sv
// adrc_ctrl_tb.sv: self-checking bench for the converter control block
// assumes: bus driven on falling edges, analog model as the far side
`timescale 1ns/1ps
module adrc_ctrl_tb;
	reg          clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
	reg          ack = 1'b0, disable_on_end_select = 1'b0, cnt_nz = 1'b0, trig = 1'b1;
	reg          hi = 1'b0, slow = 1'b0, rd_q = 1'b0;
	reg  [3:0]   addr = 4'h0;
	reg  [7:0]   wdata = 8'h00;
	reg  [5:0]   seed = 6'h00;
	wire [7:0]   rdata;
	wire [3:0]   ch;
	wire [9:0]   cdata;
	wire         busy, done, req;
	logic [7:0]  expq[$];
	logic [15:0] res[4];
	logic [7:0]  s, mode;
	int          num_errors = 0, cmp_count = 0, n, t, nsl;
	// ----------------
	// harness
	// ----------------
	initial forever #2 clk = ~clk;
	adrc_ctrl u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .bus_addr_i(addr),
		.bus_rd_i(rd), .bus_wr_i(wr), .bus_wdata_i(wdata),
		.bus_rdata_o(rdata), .xfer_ack_i(ack), .xfer_disable_on_end_select_i(disable_on_end_select),
		.xfer_cnt_nz_i(cnt_nz), .ext_trig_i(trig), .ch_hi_sel_i(hi),
		.conv_done_i(done), .conv_data_i(cdata), .ana_ch_o(ch),
		.conv_busy_o(busy), .end_req_o(req));
	adrc_ana_model u_ana (.clk_i(clk), .busy_i(busy), .slow_i(slow),
		.ch_i(ch), .seed_i(seed), .done_o(done), .data_o(cdata));
	task chk(input logic [15:0] seen, input logic [15:0] exp, string what);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task tally_and_finish;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wr8(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task rd8(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		expq.push_back(e);
		@(negedge clk);
		rd = 1'b0;
	endtask
	task wait_req(input int lim);
		n = 0;
		while (req !== 1'b1 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= lim)
		begin
			num_errors++;
			tally_and_finish;
		end
	endtask
	// read data is answered one cycle after the read edge
	always @(posedge clk) rd_q <= rd;
	always @(negedge clk)
		if (rd_q)
			chk(rdata, expq.pop_front(), "rdata");
	initial
	begin
		res = '{default: 16'h0000};
		void'($urandom(81787));
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		for (int a = 0; a < 13; a++)
			rd8(4'(a), 8'h00);
		for (int k = 0; k < 6; k++)
		begin
			s = 8'((k < 4) ? k : k - 2);
			mode = (k < 4) ? 8'h10 : 8'h00;
			hi = (k > 3);
			slow = k[0];
			seed = 6'($urandom);
			t = 512 >> k[1:0];
			nsl = mode[4] ? s + 1 : 1;
			wr8(4'h9, {4'h0, 2'(k), 2'b00});
			wr8(4'h8, 8'h20 | mode | s);
			wait_req(3000);
			chk(16'(n >= nsl * (t - 1) && n <= nsl * (t + 4)), 16'h1, "time");
			for (int j = 0; j < 4; j++)
				if (mode[4] ? j <= s : j == s)
					res[j] = {4'(j + ((hi && j > 1) ? 12 : 0)), seed, 6'h00};
			if (k == 0)
				wr8(4'h8, mode | s);
			rd8(4'h8, 8'h80 | mode | s);
			if (k[0])
			begin
				ack = 1'b1;
				disable_on_end_select = 1'b1;
				cnt_nz = 1'b1;
				rd8(4'h0, res[0][15:8]);
				rd8(4'h8, 8'h80 | mode | s);
				disable_on_end_select = 1'b0;
				rd8(4'h0, res[0][15:8]);
				ack = 1'b0;
			end
			else
				wr8(4'h8, mode | s);
			rd8(4'h8, mode | s);
			for (int j = 0; j < 4; j++)
			begin
				rd8(4'(2 * j), res[j][15:8]);
				rd8(4'(2 * j + 1), res[j][7:0]);
			end
		end
		wr8(4'h8, 8'h01);
		for (int e = 0; e < 2; e++)
		begin
			wr8(4'h9, e ? 8'h3c : 8'h2c);
			trig = 1'b0;
			repeat (6) @(negedge clk);
			chk(busy, 16'(e), "trigger start");
			trig = 1'b1;
		end
		wait_req(300);
		res[1] = {4'h1, seed, 6'h00};
		rd8(4'h8, 8'h81);
		rd8(4'h2, res[1][15:8]);
		repeat (3) @(negedge clk);
		tally_and_finish;
	end
endmodule
